// ---- core/eps_regs.svh ----
// register offsets, field positions, reset values and mode codes of the pwm steering block
`ifndef EPS_REGS_SVH
`define EPS_REGS_SVH

`define EPS_ADDR_MODE       3'h0
`define EPS_ADDR_SHUTDOWN   3'h1
`define EPS_ADDR_DEADBAND   3'h2
`define EPS_ADDR_STEER      3'h3
`define EPS_ADDR_DUTY_HIGH  3'h4
`define EPS_ADDR_PERIOD     3'h5
`define EPS_ADDR_CC_HIGH    3'h6
`define EPS_ADDR_FLAGS      3'h7

`define EPS_MODE_RST        8'h00
`define EPS_SD_RST          7'h00
`define EPS_DB_RST          8'h00
`define EPS_STEER_RST       5'h01
`define EPS_BYTE_RST        8'h00

`define EPS_SD_FLAG_BIT     7
`define EPS_RESTART_BIT     7
`define EPS_STEER_SYNC_BIT  4
`define EPS_FLAG_PERIOD_BIT 0
`define EPS_FLAG_CC_BIT     1

`define EPS_MODE_OFF        4'h0
`define EPS_CMP_TOGGLE      4'h2
`define EPS_CAP_FALL        4'h4
`define EPS_CAP_RISE        4'h5
`define EPS_CAP_4TH         4'h6
`define EPS_CAP_16TH        4'h7
`define EPS_CMP_SET         4'h8
`define EPS_CMP_CLEAR       4'h9
`define EPS_CMP_SOFT        4'hA
`define EPS_CMP_SPECIAL     4'hB

`define EPS_CFG_SINGLE      2'h0
`define EPS_CFG_HALF        2'h2

`endif

// ---- core/eps_pkg.sv ----
// types of the pwm steering and shutdown block
package eps_pkg;

	typedef struct packed {
		logic [7:0] modeCtl;
		logic [6:0] sdCtl;
		logic       sdFlag;
		logic [7:0] dbCtl;
		logic [4:0] steerReg;
		logic [1:0] steerEff;
		logic [7:0] dutyHigh;
		logic [7:0] periodLimit;
		logic [7:0] ccHigh;
		logic [9:0] timeBase;
		logic [6:0] dlyA;
		logic [6:0] dlyB;
		logic       pwmRun;
		logic       ptFlag;
		logic       ccFlag;
		logic       ccPin;
		logic       capPrev;
		logic [3:0] capCnt;
		logic       matchPrev;
		logic       compSync;
		logic       timerResetPulse;
		logic       adcStartPulse;
		logic [7:0] rdData;
	} eps_state_type;

endpackage

// ---- core/eps_steer_shutdown.sv ----
// enhanced capture/compare/pwm block with steering, dead band and auto-shutdown
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "eps_regs.svh"

module eps_steer_shutdown (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic [2:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [7:0]  regRdData,
	input  wire logic        faultInput,
	input  wire logic        compLow,
	input  wire logic        comparatorSyncEnable,
	input  wire logic        timer1Tick,
	input  wire logic [15:0] timerCount,
	input  wire logic        captureIn,
	input  wire logic        adcEnable,
	output logic             timerResetPulse,
	output logic             adcStartPulse,
	output logic             periodTimerFlag,
	output logic             captureCompareFlag,
	output logic             shutdownActive,
	output logic             pwmOutA,
	output logic             pwmOutAOe,
	output logic             pwmOutAOwn,
	output logic             pwmOutB,
	output logic             pwmOutBOe,
	output logic             pwmOutBOwn
);

	eps_pkg::eps_state_type st;
	eps_pkg::eps_state_type next_st;

	logic       pwmMode;
	logic [1:0] outCfg;
	logic       halfBridge;
	logic       singleOut;
	logic [9:0] dutyValue;
	logic       periodStart;
	logic       rawPwm;
	logic       actA;
	logic       actB;
	logic       compEff;
	logic       sdCond;
	logic       ccMatch;
	logic       matchEvent;
	logic       capRise;
	logic       capFall;
	logic       capTake;
	logic [3:0] capLimit;
	logic       modeWrite;
	logic       wrSd;
	logic       wrSteer;
	logic       wrFlags;

	// shutdown source decode; reserved codes never shut down
	function automatic logic srcActive(input logic [2:0] sel, input logic fLow, input logic cLow);
		case (sel)
			3'h7, 3'h5: srcActive = fLow | cLow;
			3'h4:       srcActive = fLow;
			3'h3, 3'h1: srcActive = cLow;
			default:    srcActive = 1'b0;
		endcase
	endfunction

	// pin drive for one output: {own, oe, level}
	function automatic logic [2:0] pinDrive(input logic own, input logic act, input logic lowPol,
		input logic sd, input logic [1:0] sdState);
		if (!own) begin
			pinDrive = 3'b000;
		end else if (sd) begin
			pinDrive = sdState[1] ? 3'b100 : {2'b11, sdState[0]};
		end else begin
			pinDrive = {2'b11, act ^ lowPol};
		end
	endfunction

	assign pwmMode    = (st.modeCtl[3:2] == 2'b11);
	assign outCfg     = st.modeCtl[7:6];
	assign halfBridge = pwmMode && (outCfg == `EPS_CFG_HALF);
	assign singleOut  = pwmMode && (outCfg == `EPS_CFG_SINGLE);
	assign dutyValue  = {st.dutyHigh, st.modeCtl[5:4]};
	assign periodStart = pwmMode && (st.timeBase == {st.periodLimit, 2'b11});
	assign rawPwm     = st.pwmRun && (st.timeBase < dutyValue);
	// dead band holds the rising edge; a delay longer than the pulse never lets it through
	assign actA = halfBridge ? (rawPwm && st.dlyA == 7'h00) : rawPwm;
	assign actB = st.pwmRun && !rawPwm && st.dlyB == 7'h00;
	// with sync enabled the comparator can start a shutdown only through its sampled level; the fault input stays live
	assign compEff = comparatorSyncEnable ? st.compSync : compLow;
	assign sdCond  = srcActive(st.sdCtl[6:4], !faultInput, compEff);
	// shutdown uses the live level so the pins react before any edge
	assign shutdownActive = st.sdFlag | sdCond;
	assign ccMatch    = (timerCount == {st.ccHigh, st.dutyHigh});
	assign matchEvent = ccMatch && !st.matchPrev;
	assign capRise    = captureIn && !st.capPrev;
	assign capFall    = !captureIn && st.capPrev;
	assign modeWrite  = regWrite && regAddr == `EPS_ADDR_MODE;
	assign wrSd       = regWrite && regAddr == `EPS_ADDR_SHUTDOWN;
	assign wrSteer    = regWrite && regAddr == `EPS_ADDR_STEER;
	assign wrFlags    = regWrite && regAddr == `EPS_ADDR_FLAGS;

	always_comb begin
		case (st.modeCtl[3:0])
			`EPS_CAP_16TH: capLimit = 4'hF;
			`EPS_CAP_4TH:  capLimit = 4'h3;
			default:       capLimit = 4'h0;
		endcase
		case (st.modeCtl[3:0])
			`EPS_CAP_FALL:                           capTake = capFall;
			`EPS_CAP_RISE, `EPS_CAP_4TH, `EPS_CAP_16TH: capTake = capRise && st.capCnt == capLimit;
			default:                                 capTake = 1'b0;
		endcase
	end

	always_comb begin
		logic [2:0] drvA;
		logic [2:0] drvB;
		drvA = 3'b000;
		drvB = 3'b000;
		if (singleOut) begin
			drvA = pinDrive(st.steerEff[0], rawPwm, st.modeCtl[1], shutdownActive, st.sdCtl[3:2]);
			drvB = pinDrive(st.steerEff[1], rawPwm, st.modeCtl[0], shutdownActive, st.sdCtl[1:0]);
		end else if (halfBridge) begin
			drvA = pinDrive(1'b1, actA, st.modeCtl[1], shutdownActive, st.sdCtl[3:2]);
			drvB = pinDrive(1'b1, actB, st.modeCtl[0], shutdownActive, st.sdCtl[1:0]);
		end else if (!pwmMode) begin
			// compare modes that own the pin; the rest leave both pins to the port
			case (st.modeCtl[3:0])
				`EPS_CMP_SET, `EPS_CMP_CLEAR, `EPS_CMP_TOGGLE: drvA = {2'b11, st.ccPin};
				default:                                      drvA = 3'b000;
			endcase
		end
		pwmOutAOwn = drvA[2];
		pwmOutAOe  = drvA[1];
		pwmOutA    = drvA[0];
		pwmOutBOwn = drvB[2];
		pwmOutBOe  = drvB[1];
		pwmOutB    = drvB[0];
	end

	always_comb begin
		next_st = st;
		next_st.timerResetPulse = 1'b0;
		next_st.adcStartPulse   = 1'b0;
		next_st.matchPrev = ccMatch;
		next_st.capPrev   = captureIn;

		if (regWrite) begin
			case (regAddr)
				`EPS_ADDR_MODE:      next_st.modeCtl = regWrData;
				`EPS_ADDR_SHUTDOWN:  next_st.sdCtl = regWrData[6:0];
				`EPS_ADDR_DEADBAND:  next_st.dbCtl = regWrData;
				`EPS_ADDR_STEER:     next_st.steerReg = {regWrData[4], 2'b00, regWrData[1:0]};
				`EPS_ADDR_DUTY_HIGH: next_st.dutyHigh = regWrData;
				`EPS_ADDR_PERIOD:    next_st.periodLimit = regWrData;
				`EPS_ADDR_CC_HIGH:   next_st.ccHigh = regWrData;
				default:             next_st.modeCtl = st.modeCtl;
			endcase
		end

		if (timer1Tick) begin
			next_st.compSync = compLow;
		end

		// level shutdown wins over a write; auto-restart also drops a firmware shutdown
		if (sdCond) begin
			next_st.sdFlag = 1'b1;
		end else if (st.dbCtl[`EPS_RESTART_BIT]) begin
			next_st.sdFlag = 1'b0;
		end else if (wrSd) begin
			next_st.sdFlag = regWrData[`EPS_SD_FLAG_BIT];
		end

		// time base: instruction-cycle bits below the 8-bit period timer
		if (!pwmMode || periodStart) begin
			next_st.timeBase = 10'h000;
		end else begin
			next_st.timeBase = st.timeBase + 10'h001;
		end

		if (!pwmMode || shutdownActive) begin
			next_st.pwmRun = 1'b0;
		end else if (periodStart) begin
			next_st.pwmRun = 1'b1;
		end

		next_st.dlyA = rawPwm ? ((st.dlyA != 7'h00) ? st.dlyA - 7'h01 : 7'h00) : st.dbCtl[6:0];
		next_st.dlyB = (st.pwmRun && !rawPwm) ? ((st.dlyB != 7'h00) ? st.dlyB - 7'h01 : 7'h00)
			: st.dbCtl[6:0];

		if (wrSteer && !regWrData[`EPS_STEER_SYNC_BIT]) begin
			next_st.steerEff = regWrData[1:0];
		end else if (periodStart && st.steerReg[`EPS_STEER_SYNC_BIT]) begin
			next_st.steerEff = st.steerReg[1:0];
		end

		if (periodStart) begin
			next_st.ptFlag = 1'b1;
		end else if (wrFlags && regWrData[`EPS_FLAG_PERIOD_BIT]) begin
			next_st.ptFlag = 1'b0;
		end

		if (capRise && capLimit != 4'h0) begin
			next_st.capCnt = (st.capCnt == capLimit) ? 4'h0 : st.capCnt + 4'h1;
		end
		if (capTake) begin
			next_st.ccHigh   = timerCount[15:8];
			next_st.dutyHigh = timerCount[7:0];
		end

		if (!pwmMode && matchEvent) begin
			case (st.modeCtl[3:0])
				`EPS_CMP_CLEAR:  next_st.ccPin = 1'b0;
				`EPS_CMP_SET:    next_st.ccPin = 1'b1;
				`EPS_CMP_TOGGLE: next_st.ccPin = !st.ccPin;
				`EPS_CMP_SPECIAL: begin
					next_st.timerResetPulse = 1'b1;
					next_st.adcStartPulse   = adcEnable;
				end
				default:         next_st.ccPin = st.ccPin;
			endcase
		end

		// a new event beats a clear in the same cycle
		if (capTake || (matchEvent && st.modeCtl[3])) begin
			next_st.ccFlag = 1'b1;
		end else if (wrFlags && regWrData[`EPS_FLAG_CC_BIT]) begin
			next_st.ccFlag = 1'b0;
		end

		// entering clear or set compare mode from any mode but off presets the pin; off clears the compare pin and the capture count
		if (modeWrite) begin
			next_st.capCnt = 4'h0;
			if (regWrData[3:0] == `EPS_CMP_CLEAR) begin
				next_st.ccPin = 1'b1;
			end else if (regWrData[3:0] == `EPS_CMP_SET) begin
				next_st.ccPin = 1'b0;
			end
		end
		if (st.modeCtl[3:0] == `EPS_MODE_OFF) begin
			next_st.ccPin  = 1'b0;
			next_st.capCnt = 4'h0;
		end

		next_st.rdData = 8'h00;
		if (regRead) begin
			case (regAddr)
				`EPS_ADDR_MODE:      next_st.rdData = st.modeCtl;
				`EPS_ADDR_SHUTDOWN:  next_st.rdData = {st.sdFlag, st.sdCtl};
				`EPS_ADDR_DEADBAND:  next_st.rdData = st.dbCtl;
				`EPS_ADDR_STEER:     next_st.rdData = {3'b000, st.steerReg};
				`EPS_ADDR_DUTY_HIGH: next_st.rdData = st.dutyHigh;
				`EPS_ADDR_PERIOD:    next_st.rdData = st.periodLimit;
				`EPS_ADDR_CC_HIGH:   next_st.rdData = st.ccHigh;
				`EPS_ADDR_FLAGS:     next_st.rdData = {6'h00, st.ccFlag, st.ptFlag};
				default:             next_st.rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st             <= '0;
			st.modeCtl     <= `EPS_MODE_RST;
			st.sdCtl       <= `EPS_SD_RST;
			st.dbCtl       <= `EPS_DB_RST;
			st.steerReg    <= `EPS_STEER_RST;
			// the effective copy keeps only the two enable bits of the reset value
			st.steerEff    <= 2'(`EPS_STEER_RST);
			st.dutyHigh    <= `EPS_BYTE_RST;
			st.periodLimit <= `EPS_BYTE_RST;
			st.ccHigh      <= `EPS_BYTE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign regRdData          = st.rdData;
	assign timerResetPulse    = st.timerResetPulse;
	assign adcStartPulse      = st.adcStartPulse;
	assign periodTimerFlag    = st.ptFlag;
	assign captureCompareFlag = st.ccFlag;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence deadStart;
		halfBridge && $rose(rawPwm) && st.dbCtl[6:0] == 7'h02 && $stable(st.dbCtl);
	endsequence

	sequence heldOff;
		!actA ##1 !actA;
	endsequence

	AST_SD_FLAG_SET: assert property (sdCond |=> st.sdFlag)
		else $error("shutdown flag not set by shutdown level");
	AST_SD_WRITE_IGNORED: assert property (sdCond && wrSd && !regWrData[7] |=> st.sdFlag)
		else $error("flag cleared while shutdown level present");
	AST_AUTO_RESTART: assert property (!sdCond && st.dbCtl[7] && st.sdFlag |=> !st.sdFlag)
		else $error("auto-restart did not clear shutdown flag");
	AST_SD_TRISTATE_A: assert property (halfBridge && shutdownActive && st.sdCtl[3] |-> !pwmOutAOe)
		else $error("pin A driven in tri-state shutdown");
	AST_STEER_NOW: assert property (wrSteer && !regWrData[4] |=> st.steerEff == $past(regWrData[1:0]))
		else $error("unsynced steering not applied");
	AST_STEER_DEFER: assert property (st.steerReg[4] && !periodStart && !wrSteer |=> $stable(st.steerEff))
		else $error("synced steering changed mid period");
	AST_PERIOD_FLAG: assert property (periodStart |=> st.ptFlag && st.timeBase == 10'h000)
		else $error("period start did not set flag and restart time base");
	AST_DEADBAND: assert property (deadStart |-> heldOff)
		else $error("dead band delay too short");
	AST_MODE_OFF: assert property (st.modeCtl == 8'h00 |=> !st.pwmRun && st.timeBase == 10'h000)
		else $error("module not reset in off mode");
	AST_CMP_CLEAR: assert property (st.modeCtl[3:0] == 4'h9 && matchEvent && !modeWrite
		|=> !st.ccPin && st.ccFlag)
		else $error("clear-on-match compare failed");
	AST_RESTART_PERIOD: assert property ($rose(st.pwmRun) |-> $past(periodStart))
		else $error("pwm resumed outside period start");

	// pins follow the shutdown level in the same cycle, before the flag is set
	AST_SD_PINS_NOW: assert property (halfBridge && sdCond && !st.sdCtl[3]
		|-> pwmOutAOe && pwmOutA == st.sdCtl[2])
		else $error("pin A not at its shutdown level at once");
	AST_SYNC_HOLD: assert property (comparatorSyncEnable && !st.compSync && !st.sdFlag
		&& st.sdCtl[4] && !st.sdCtl[6] |-> !shutdownActive)
		else $error("unsampled comparator level started a shutdown");
	AST_SD_STOPS_RUN: assert property (shutdownActive |=> !st.pwmRun)
		else $error("pwm kept running through a shutdown");

	// compare and capture events, checked one cycle after the event
	AST_SPECIAL_PULSE: assert property (!pwmMode && st.modeCtl[3:0] == `EPS_CMP_SPECIAL && matchEvent
		|=> timerResetPulse && adcStartPulse == $past(adcEnable))
		else $error("special event match gave a wrong timer reset or conversion start");
	AST_CMP_SET: assert property (st.modeCtl[3:0] == `EPS_CMP_SET && matchEvent && !modeWrite
		|=> st.ccPin && st.ccFlag)
		else $error("set-on-match compare failed");
	AST_CMP_TOGGLE: assert property (st.modeCtl[3:0] == `EPS_CMP_TOGGLE && matchEvent && !modeWrite
		|=> st.ccPin != $past(st.ccPin))
		else $error("toggle compare did not toggle the pin");
	AST_CAPTURE_TAKE: assert property (capTake
		|=> st.ccFlag && {st.ccHigh, st.dutyHigh} == $past(timerCount))
		else $error("capture did not store the timer value");

	// pins that the selected mode hands back to the port
	AST_CMP_SOFT_FREE: assert property (st.modeCtl[3:0] == `EPS_CMP_SOFT |-> !pwmOutAOwn && !pwmOutBOwn)
		else $error("soft-interrupt compare kept a pin");
	AST_PORT_B_FREE: assert property (!pwmMode |-> !pwmOutBOwn)
		else $error("pin B held outside pwm mode");
	AST_OFF_RELEASE: assert property (st.modeCtl[3:0] == `EPS_MODE_OFF |-> !pwmOutAOwn && !pwmOutBOwn)
		else $error("pins held in off mode");

endmodule
`default_nettype wire

// ---- test/eps_load_model.sv ----
// external load on the two pwm pins: pull-down resistors and a shoot-through monitor
`timescale 1ns/10ps
`default_nettype none

module eps_load_model (
	input  wire logic pinA,
	input  wire logic oeA,
	input  wire logic pinB,
	input  wire logic oeB,
	output logic      padA,
	output logic      padB,
	output logic      shoot
);
	// an undriven pin sits at the pull-down level, so tri-state reads as off
	assign padA = oeA ? pinA : 1'b0;
	assign padB = oeB ? pinB : 1'b0;
	// both switches on at once would short the bridge supply
	assign shoot = padA & padB;
endmodule

`default_nettype wire

// ---- test/tb_eps_steer_shutdown.sv ----
// register-level testbench of the pwm steering and shutdown block
`timescale 1ns/10ps
`default_nettype none

module tb_eps_steer_shutdown;
	logic        ref_clk = 0, nrst = 0, regWrite = 0, regRead = 0;
	logic [2:0]  regAddr = 0;
	logic [7:0]  regWrData = 0, regRdData;
	logic        faultInput = 1, compLow = 0, comparatorSyncEnable = 0, timer1Tick = 0;
	logic [15:0] timerCount = 0;
	logic        captureIn = 0, adcEnable = 1;
	logic        timerResetPulse, adcStartPulse, periodTimerFlag, captureCompareFlag, shutdownActive;
	logic        pwmOutA, pwmOutAOe, pwmOutAOwn, pwmOutB, pwmOutBOe, pwmOutBOwn;
	logic        padA, padB, shoot, p;
	logic [3:0]  m;
	logic [2:0]  srcList [6] = '{3'h7, 3'h5, 3'h4, 3'h3, 3'h1, 3'h0};
	logic [3:0]  cmpList [5] = '{4'h9, 4'h8, 4'h2, 4'hA, 4'hB};
	int          capN [4] = '{1, 1, 4, 16};
	int          errorCnt = 0, checkCount = 0, a, b, s, i, j;

	always #2 ref_clk = ~ref_clk;

	eps_steer_shutdown u_eps_steer_shutdown (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.faultInput(faultInput), .compLow(compLow), .comparatorSyncEnable(comparatorSyncEnable),
		.timer1Tick(timer1Tick), .timerCount(timerCount), .captureIn(captureIn), .adcEnable(adcEnable),
		.timerResetPulse(timerResetPulse), .adcStartPulse(adcStartPulse), .periodTimerFlag(periodTimerFlag),
		.captureCompareFlag(captureCompareFlag), .shutdownActive(shutdownActive), .pwmOutA(pwmOutA),
		.pwmOutAOe(pwmOutAOe), .pwmOutAOwn(pwmOutAOwn), .pwmOutB(pwmOutB), .pwmOutBOe(pwmOutBOe),
		.pwmOutBOwn(pwmOutBOwn));

	eps_load_model u_eps_load_model (.pinA(pwmOutA), .oeA(pwmOutAOe), .pinB(pwmOutB), .oeB(pwmOutBOe),
		.padA(padA), .padB(padB), .shoot(shoot));

	task conclude;
		if (errorCnt == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge ref_clk);
		regWrite <= 1;
		regAddr <= ad;
		regWrData <= d;
		@(posedge ref_clk);
		regWrite <= 0;
		#1;
	endtask

	task rd(input logic [2:0] ad, input logic [7:0] e);
		@(posedge ref_clk);
		regRead <= 1;
		regAddr <= ad;
		@(posedge ref_clk);
		regRead <= 0;
		#1 chk(regRdData, e);
	endtask

	// clears the period flag and waits for the next period start
	task waitPeriod;
		int k;
		wr(3'h7, 8'h01);
		for (k = 0; k < 100 && periodTimerFlag !== 1'b1; k++)
			@(negedge ref_clk);
		chk(8'(periodTimerFlag), 8'h01);
		if (periodTimerFlag !== 1'b1)
			conclude;
	endtask

	// the waveform repeats every 16 cycles, so any 16-cycle window gives the duty
	task cnt;
		a = 0;
		b = 0;
		s = 0;
		repeat (16) begin
			@(negedge ref_clk);
			a += (padA === 1'b1);
			b += (padB === 1'b1);
			s += (shoot === 1'b1);
		end
	endtask

	task capPulse;
		@(posedge ref_clk);
		captureIn <= 1;
		repeat (2) @(posedge ref_clk);
		captureIn <= 0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	initial begin
		#200000;
		errorCnt++;
		conclude;
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1;
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h00);
		rd(3'h2, 8'h00);
		rd(3'h3, 8'h01);
		wr(3'h3, 8'hff);
		rd(3'h3, 8'h13);
		wr(3'h3, 8'h01);
		wr(3'h5, 8'h03);
		wr(3'h4, 8'h02);
		wr(3'h0, 8'h1c);
		waitPeriod;
		waitPeriod;
		cnt;
		chk(8'(a), 8'h09);
		chk(8'(b), 8'h00);
		wr(3'h0, 8'h1e);
		waitPeriod;
		cnt;
		chk(8'(a), 8'h07);
		waitPeriod;
		wr(3'h3, 8'h02);
		@(posedge ref_clk);
		#1 chk(8'(pwmOutAOwn), 8'h00);
		chk(8'(pwmOutBOwn), 8'h01);
		cnt;
		chk(8'(b), 8'h09);
		waitPeriod;
		wr(3'h3, 8'h11);
		@(posedge ref_clk);
		#1 chk(8'(pwmOutAOwn), 8'h00);
		chk(8'(pwmOutBOwn), 8'h01);
		waitPeriod;
		chk(8'(pwmOutAOwn), 8'h01);
		chk(8'(pwmOutBOwn), 8'h00);
		wr(3'h0, 8'hcc);
		chk(8'(pwmOutAOwn | pwmOutBOwn), 8'h00);
		wr(3'h2, 8'h02);
		wr(3'h0, 8'h8c);
		waitPeriod;
		waitPeriod;
		cnt;
		chk(8'(a), 8'h06);
		chk(8'(b), 8'h06);
		chk(8'(s), 8'h00);
		wr(3'h2, 8'h0a);
		waitPeriod;
		waitPeriod;
		cnt;
		chk(8'(a + b), 8'h00);
		wr(3'h2, 8'h02);
		wr(3'h1, 8'h44);
		@(posedge ref_clk);
		faultInput <= 0;
		#1 chk(8'({pwmOutA, pwmOutB, shutdownActive}), 8'h05);
		rd(3'h1, 8'hc4);
		wr(3'h1, 8'h44);
		rd(3'h1, 8'hc4);
		@(posedge ref_clk);
		faultInput <= 1;
		rd(3'h1, 8'hc4);
		wr(3'h1, 8'h44);
		rd(3'h1, 8'h44);
		wr(3'h1, 8'h49);
		@(posedge ref_clk);
		faultInput <= 0;
		#1 chk(8'({pwmOutAOe, padA, pwmOutB}), 8'h01);
		@(posedge ref_clk);
		faultInput <= 1;
		wr(3'h2, 8'h82);
		repeat (3) @(posedge ref_clk);
		rd(3'h1, 8'h49);
		for (i = 0; i < 6; i++) begin
			wr(3'h1, {1'b0, srcList[i], 4'h4});
			@(posedge ref_clk);
			faultInput <= 0;
			#1 chk(8'(shutdownActive), {7'h00, srcList[i][2]});
			@(posedge ref_clk);
			faultInput <= 1;
			repeat (2) @(posedge ref_clk);
			compLow <= 1;
			#1 chk(8'(shutdownActive), {7'h00, srcList[i][0]});
			@(posedge ref_clk);
			compLow <= 0;
			repeat (2) @(posedge ref_clk);
		end
		wr(3'h1, 8'h14);
		@(posedge ref_clk);
		comparatorSyncEnable <= 1;
		compLow <= 1;
		repeat (3) @(posedge ref_clk);
		#1 chk(8'(shutdownActive), 8'h00);
		@(posedge ref_clk);
		timer1Tick <= 1;
		@(posedge ref_clk);
		timer1Tick <= 0;
		#1 chk(8'(shutdownActive), 8'h01);
		@(posedge ref_clk);
		compLow <= 0;
		timer1Tick <= 1;
		@(posedge ref_clk);
		timer1Tick <= 0;
		comparatorSyncEnable <= 0;
		wr(3'h1, 8'h00);
		wr(3'h6, 8'h00);
		wr(3'h4, 8'h05);
		for (i = 0; i < 5; i++) begin
			m = cmpList[i];
			wr(3'h0, {4'h0, m});
			wr(3'h7, 8'h03);
			p = pwmOutA;
			if (m[3:1] == 3'h4)
				chk(8'(p), {7'h00, m[0]});
			chk(8'(pwmOutAOwn), {7'h00, m[3:1] != 3'h5});
			chk(8'(pwmOutBOwn), 8'h00);
			@(posedge ref_clk);
			timerCount <= 16'h0005;
			@(posedge ref_clk);
			timerCount <= 16'h0000;
			#1 chk({6'h00, timerResetPulse, adcStartPulse}, {6'h00, {2{m == 4'hB}}});
			// the toggle compare mode raises no flag in this block
			chk(8'(captureCompareFlag), {7'h00, m[3]});
			if (m[3:1] != 3'h5)
				chk(8'(pwmOutA), {7'h00, m == 4'h2 ? ~p : m == 4'h8});
		end
		// a special event match with the converter off resets the timer only
		@(posedge ref_clk);
		adcEnable <= 0;
		wr(3'h0, 8'h0b);
		@(posedge ref_clk);
		timerCount <= 16'h0005;
		@(posedge ref_clk);
		timerCount <= 16'h1234;
		#1 chk({6'h00, timerResetPulse, adcStartPulse}, 8'h02);
		for (i = 0; i < 4; i++) begin
			wr(3'h0, 8'h00);
			wr(3'h0, 8'h04 + 8'(i));
			wr(3'h7, 8'h03);
			for (j = 0; j < capN[i]; j++) begin
				if (j == capN[i] - 1)
					chk(8'(captureCompareFlag), 8'h00);
				capPulse;
			end
			chk(8'(captureCompareFlag), 8'h01);
			rd(3'h4, 8'h34);
			rd(3'h6, 8'h12);
		end
		wr(3'h0, 8'h00);
		chk(8'({pwmOutAOwn, pwmOutBOwn, pwmOutAOe, pwmOutBOe}), 8'h00);
		conclude;
	end
endmodule

`default_nettype wire
